//--- uart_baud_generator_timer_tb_top.sv
// self-checking bench for the bit rate generator / timer
// assumes the uart partner model only watches the rate strobes
`timescale 1ns/1ps
`default_nettype none
module uart_baud_generator_timer_tb_top;
  import ubg_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_stop_recover = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_x16_tick, o_bit_tick, o_timer_mode, o_tx_enable, o_rx_enable;
  logic o_parity_enable, o_parity_odd, o_two_stop, o_send_break, o_irq;
  logic [15:0] x16_per, bit_per, x16_cnt, bit_cnt;
  int err_count = 0;
  int checks_done = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  ubg_baud_timer DUT (.i_sys_clk, .i_rst, .i_stop_recover, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_x16_tick, .o_bit_tick, .o_timer_mode, .o_tx_enable, .o_rx_enable,
    .o_parity_enable, .o_parity_odd, .o_two_stop, .o_send_break, .o_irq);
  ubg_uart_model uart (.i_sys_clk, .i_rst, .i_x16_tick(o_x16_tick), .i_bit_tick(o_bit_tick),
    .o_x16_per(x16_per), .o_bit_per(bit_per), .o_x16_cnt(x16_cnt), .o_bit_cnt(bit_cnt));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask : rchk
  // timer reloads every few cycles, so 400 is ample
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (o_irq !== lvl && n < 400) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk({15'h0000, o_irq}, {15'h0000, lvl});
    if (n == 400) end_sim();
  endtask : wait_irq
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(UBG_DIV_OFS, UBG_DIV_RST);
    rchk(UBG_CTRL_OFS, 8'h00);
    rchk(UBG_IEN_OFS, 8'h03);
    rchk(8'h10, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ctrl();
    wr(UBG_CTRL_OFS, 8'h9a);
    chk({9'h000, o_tx_enable, o_rx_enable, o_parity_enable, o_parity_odd, o_send_break,
      o_two_stop, o_timer_mode}, 16'h005a);
    wr(UBG_CTRL_OFS, 8'h44);
    chk({9'h000, o_tx_enable, o_rx_enable, o_parity_enable, o_parity_odd, o_send_break,
      o_two_stop, o_timer_mode}, 16'h0024);
    wr(UBG_CTRL_OFS, 8'h00);
    $display("test control done");
  endtask : t_ctrl
  task automatic t_rate(input logic [7:0] dv, input logic [15:0] per);
    logic [15:0] b;
    int n;
    wr(UBG_DIV_OFS, dv);
    rchk(UBG_DIV_OFS, dv);
    b = bit_cnt;
    n = 0;
    while (bit_cnt < b + 16'h0003 && n < 20000) begin
      @(posedge i_sys_clk);
      n++;
    end
    chk(x16_per, per);
    chk(bit_per, per << 4);
    if (n == 20000) begin
      err_count++;
      end_sim();
    end
    $display("test rate done");
  endtask : t_rate
  task automatic t_timer();
    logic [7:0] v1;
    logic [7:0] v2;
    logic [15:0] b;
    wr(UBG_DIV_OFS, 8'h0a);
    wr(UBG_CTRL_OFS, 8'h21);
    b = x16_cnt;
    chk({15'h0000, o_timer_mode}, 16'h0001);
    rd(UBG_DIV_OFS, v1);
    rd(UBG_DIV_OFS, v2);
    chk({8'h00, v2}, {8'h00, (v1 > 8'h02) ? v1 - 8'h02 : v1 + 8'h08});
    wait_irq(1'b1);
    rchk(UBG_STAT_OFS, 8'h01);
    wr(UBG_CTRL_OFS, 8'h01);
    wr(UBG_CLR_OFS, 8'h01);
    chk({15'h0000, o_irq}, 16'h0000);
    wr(UBG_CTRL_OFS, 8'h21);
    wait_irq(1'b1);
    wr(UBG_IEN_OFS, 8'h00);
    chk({15'h0000, o_irq}, 16'h0000);
    rchk(UBG_IEN_OFS, 8'h00);
    wr(UBG_IEN_OFS, 8'h03);
    chk(x16_cnt - b, 16'h0000);
    wr(UBG_CTRL_OFS, 8'h00);
    wr(UBG_CLR_OFS, 8'h03);
    $display("test timer done");
  endtask : t_timer
  task automatic t_refuse();
    wr(UBG_CTRL_OFS, 8'hc1);
    chk({15'h0000, o_timer_mode}, 16'h0000);
    rchk(UBG_CTRL_OFS, 8'hc1);
    rchk(UBG_STAT_OFS, 8'h02);
    wait_irq(1'b1);
    wr(UBG_CLR_OFS, 8'h02);
    wait_irq(1'b0);
    wr(UBG_CTRL_OFS, 8'h01);
    chk({15'h0000, o_timer_mode}, 16'h0001);
    wr(UBG_CTRL_OFS, 8'h00);
    $display("test refused mode done");
  endtask : t_refuse
  task automatic t_stop();
    wr(UBG_DIV_OFS, 8'h55);
    wr(UBG_CTRL_OFS, 8'h46);
    @(posedge i_sys_clk);
    i_stop_recover <= 1'b1;
    @(posedge i_sys_clk);
    i_stop_recover <= 1'b0;
    rchk(UBG_DIV_OFS, 8'h55);
    rchk(UBG_CTRL_OFS, 8'h00);
    $display("test stop recovery done");
  endtask : t_stop
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_rate(8'h02, 16'h0002);
    t_rate(8'h00, 16'h0100);
    t_timer();
    t_refuse();
    t_stop();
    end_sim();
  end
endmodule : uart_baud_generator_timer_tb_top
`default_nettype wire

//--- ubg_baud_timer.sv
// serial bit rate generator that doubles as an 8-bit reload timer
// assumes the register port master and the uart logic share i_sys_clk
//
// Functional notes
// - timer use only takes effect while transmitter and receiver are disabled
// - timer reload raises interrupt when both the control interrupt enable and its enable mask bit are set
// - mode bit clear: bit rate source; set: standalone 8-bit timer
// - bit rate equals system clock over sixteen times divisor
// - divisor read in timer use returns running count
// - divisor write stores the new reload constant
// - divisor survives stop-mode recovery
// - bit rate equals crystal over thirty-two times divisor
`timescale 1ns/1ps
`default_nettype none
module ubg_baud_timer
  import ubg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_stop_recover,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_x16_tick,
  output logic o_bit_tick,
  output logic o_timer_mode,
  output logic o_tx_enable,
  output logic o_rx_enable,
  output logic o_parity_enable,
  output logic o_parity_odd,
  output logic o_two_stop,
  output logic o_send_break,
  output logic o_irq
);
  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  logic [7:0] serial_control_reg;
  logic [7:0] serial_control_next;
  logic [7:0] baud_divisor_constant_reg;
  logic [7:0] baud_divisor_constant_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic timer_mode_reg;
  logic timer_mode_next;
  logic wr_ctrl;
  logic wr_div;
  logic [7:0] div_count;
  logic div_tick;
  logic bit_tick;
  logic restart;
  logic mode_err;
  logic [UBG_EV_N-1:0] events;
  logic [UBG_EV_N-1:0] gates;
  logic [UBG_EV_N-1:0] status;
  logic [UBG_EV_N-1:0] ien;

  assign wr_ctrl = i_wr && (i_addr == UBG_CTRL_OFS);
  assign wr_div = i_wr && (i_addr == UBG_DIV_OFS);

  // ----------------------------------------------------------------
  // control and divisor registers
  // ----------------------------------------------------------------
  always_comb begin
    serial_control_next = serial_control_reg;
    baud_divisor_constant_next = baud_divisor_constant_reg;
    if (i_stop_recover) begin
      serial_control_next = UBG_CTRL_RST;
    end else if (wr_ctrl) begin
      serial_control_next = i_wdata;
    end
    // stop recovery leaves the divisor alone
    if (wr_div) begin
      baud_divisor_constant_next = i_wdata;
    end
    // timer use needs both serial directions off
    timer_mode_next = serial_control_next[UBG_MODE_BIT]
      && !serial_control_next[UBG_TX_EN_BIT]
      && !serial_control_next[UBG_RX_EN_BIT];
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      serial_control_reg <= UBG_CTRL_RST;
      baud_divisor_constant_reg <= UBG_DIV_RST;
      timer_mode_reg <= 1'b0;
    end else begin
      serial_control_reg <= serial_control_next;
      baud_divisor_constant_reg <= baud_divisor_constant_next;
      timer_mode_reg <= timer_mode_next;
    end
  end

  // a mode request refused because a direction is still enabled
  assign mode_err = wr_ctrl && i_wdata[UBG_MODE_BIT]
    && (i_wdata[UBG_TX_EN_BIT] || i_wdata[UBG_RX_EN_BIT]);

  // ----------------------------------------------------------------
  // bit_rate_divider and oversampling prescaler
  // ----------------------------------------------------------------
  // restart on mode change so the first period after a switch is whole
  assign restart = (timer_mode_next != timer_mode_reg) || i_stop_recover;

  ubg_down_cnt #(
    .W(8),
    .RST_VAL(UBG_DIV_RST)
  ) u_divider (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_restart(restart),
    .i_en(1'b1),
    .i_reload(baud_divisor_constant_reg),
    .o_count(div_count),
    .o_tick(div_tick)
  );

  ubg_down_cnt #(
    .W(UBG_PRE_W),
    .RST_VAL(UBG_PRE_RELOAD)
  ) u_prescale (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_restart(restart),
    .i_en(div_tick && !timer_mode_reg),
    .i_reload(UBG_PRE_RELOAD),
    .o_count(),
    .o_tick(bit_tick)
  );

  // the system clock is crystal/2, so sys/(16*d) is crystal/(32*d)
  assign o_x16_tick = div_tick && !timer_mode_reg;
  assign o_bit_tick = bit_tick;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign events[UBG_EV_RELOAD] = div_tick && timer_mode_reg;
  assign events[UBG_EV_MODE_ERR] = mode_err;
  // reload interrupt also needs the control interrupt enable
  assign gates[UBG_EV_RELOAD] = serial_control_reg[UBG_IRQ_EN_BIT];
  assign gates[UBG_EV_MODE_ERR] = 1'b1;

  ubg_irq #(
    .N(UBG_EV_N),
    .IEN_RST(UBG_IEN_RST)
  ) u_irq (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_event(events),
    .i_gate(gates),
    .i_clr_wr(i_wr && (i_addr == UBG_CLR_OFS)),
    .i_ien_wr(i_wr && (i_addr == UBG_IEN_OFS)),
    .i_wdata(i_wdata[UBG_EV_N-1:0]),
    .o_status(status),
    .o_ien(ien),
    .o_irq(o_irq)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // data stands for one cycle only; zero otherwise and for unmapped reads
  always_comb begin
    rdata_next = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        UBG_CTRL_OFS: rdata_next = serial_control_reg;
        UBG_DIV_OFS: rdata_next = timer_mode_reg ? div_count
          : baud_divisor_constant_reg;
        UBG_STAT_OFS: rdata_next = {{(8-UBG_EV_N){1'b0}}, status};
        UBG_IEN_OFS: rdata_next = {{(8-UBG_EV_N){1'b0}}, ien};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // uart control outputs
  // ----------------------------------------------------------------
  assign o_rdata = rdata_reg;
  assign o_timer_mode = timer_mode_reg;
  assign o_tx_enable = serial_control_reg[UBG_TX_EN_BIT];
  assign o_rx_enable = serial_control_reg[UBG_RX_EN_BIT];
  assign o_parity_enable = serial_control_reg[UBG_PAR_EN_BIT];
  assign o_parity_odd = serial_control_reg[UBG_PAR_ODD_BIT];
  assign o_two_stop = serial_control_reg[UBG_STOP2_BIT];
  assign o_send_break = serial_control_reg[UBG_BREAK_BIT];

  // ----------------------------------------------------------------
  // assertion helper
  // ----------------------------------------------------------------
  // counted apart from the prescaler, so the bit grid check cannot
  // inherit a fault from the counter that it watches
  logic [4:0] x16_seen_reg;
  logic [4:0] x16_seen_next;
  always_comb begin
    x16_seen_next = x16_seen_reg;
    if (restart || o_bit_tick) begin
      x16_seen_next = 5'h00;
    end else if (o_x16_tick) begin
      x16_seen_next = x16_seen_reg + 5'h01;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      x16_seen_reg <= 5'h00;
    end else begin
      x16_seen_reg <= x16_seen_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  mode_guard_a: assert property (o_timer_mode |-> !o_tx_enable && !o_rx_enable)
    else $error("timer mode with a serial direction enabled");
  mode_refuse_a: assert property (wr_ctrl && i_wdata[UBG_MODE_BIT]
    && i_wdata[UBG_TX_EN_BIT] |=> !o_timer_mode && status[UBG_EV_MODE_ERR])
    else $error("refused mode request not flagged");
  reload_irq_a: assert property (div_tick && timer_mode_reg && !restart
    && serial_control_reg[UBG_IRQ_EN_BIT] && ien[UBG_EV_RELOAD]
    && !i_wr |=> o_irq)
    else $error("timer reload gave no interrupt");
  timer_quiet_a: assert property (o_timer_mode |-> !o_bit_tick && !o_x16_tick)
    else $error("rate tick in timer mode");
  bit_tick_a: assert property (o_bit_tick |-> o_x16_tick)
    else $error("bit tick off the oversample grid");
  timer_read_a: assert property (i_rd && i_addr == UBG_DIV_OFS && timer_mode_reg
    |=> o_rdata == $past(div_count))
    else $error("timer read did not return running count");
  div_write_a: assert property (wr_div |=> baud_divisor_constant_reg == $past(i_wdata))
    else $error("divisor write lost");
  stop_keep_a: assert property (i_stop_recover && !wr_div
    |=> $stable(baud_divisor_constant_reg))
    else $error("divisor changed by stop recovery");
  reload_a: assert property (div_tick && !wr_div
    |=> div_count == baud_divisor_constant_reg)
    else $error("divider did not reload at terminal count");
  stop_bits_a: assert property (wr_ctrl && !i_stop_recover
    |=> o_two_stop == $past(i_wdata[UBG_STOP2_BIT])
    && o_send_break == $past(i_wdata[UBG_BREAK_BIT]))
    else $error("stop or break control not applied");

  bit_grid_a: assert property (o_x16_tick
    |-> o_bit_tick == (x16_seen_reg == 5'h0f))
    else $error("bit tick not on every sixteenth oversample tick");
  // the sampled reset keeps the release edge, where the counter is still held, out
  count_down_a: assert property (!i_rst && !restart && !div_tick
    |=> div_count == $past(div_count) - 8'h01)
    else $error("divider did not count down");
  div_read_a: assert property (i_rd && i_addr == UBG_DIV_OFS && !timer_mode_reg
    |=> o_rdata == $past(baud_divisor_constant_reg))
    else $error("rate read did not return the reload constant");
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  irq_gate_a: assert property (!serial_control_reg[UBG_IRQ_EN_BIT]
    && !status[UBG_EV_MODE_ERR] |-> !o_irq)
    else $error("interrupt with reload interrupt disabled");
  reload_status_a: assert property (div_tick && timer_mode_reg |=> status[UBG_EV_RELOAD])
    else $error("timer reload not recorded");
  refuse_irq_a: assert property (status[UBG_EV_MODE_ERR] && ien[UBG_EV_MODE_ERR] |-> o_irq)
    else $error("refused mode gave no interrupt");
  stop_restart_a: assert property (i_stop_recover
    |=> div_count == $past(baud_divisor_constant_reg))
    else $error("stop recovery did not restart from the divisor");
  stop_ctrl_a: assert property (i_stop_recover
    |=> serial_control_reg == UBG_CTRL_RST && !o_timer_mode)
    else $error("stop recovery left control bits set");
  mode_enter_a: assert property (wr_ctrl && !i_stop_recover && i_wdata[UBG_MODE_BIT]
    && !i_wdata[UBG_TX_EN_BIT] && !i_wdata[UBG_RX_EN_BIT]
    |=> o_timer_mode)
    else $error("timer use not entered");
  mode_leave_a: assert property (wr_ctrl && !i_wdata[UBG_MODE_BIT]
    |=> !o_timer_mode)
    else $error("rate use not restored");
  refuse_clear_a: assert property (i_wr && i_addr == UBG_CLR_OFS
    && i_wdata[UBG_EV_MODE_ERR] |=> !status[UBG_EV_MODE_ERR])
    else $error("refused mode flag not cleared");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  bit_tick_c: cover property (o_bit_tick ##[1:300] o_bit_tick);
  timer_irq_c: cover property (o_timer_mode ##[1:300] o_irq);
  timer_read_c: cover property (i_rd && i_addr == UBG_DIV_OFS && timer_mode_reg);
  refuse_c: cover property (mode_err);
  stop_c: cover property (i_stop_recover && baud_divisor_constant_reg != UBG_DIV_RST);
endmodule : ubg_baud_timer
`default_nettype wire

//--- ubg_down_cnt.sv
// reloadable down counter with a terminal-count strobe
// assumes one clock; i_restart and i_en come from the same domain
`timescale 1ns/1ps
`default_nettype none
module ubg_down_cnt #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_restart,
  input wire logic i_en,
  input wire logic [W-1:0] i_reload,
  output logic [W-1:0] o_count,
  output logic o_tick
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  // ----------------------------------------------------------------
  // count
  // ----------------------------------------------------------------
  // a reload of 0 yields a full 2**W period since 0 wraps to all ones
  assign o_tick = i_en && !i_restart && (cnt_reg == W'(1));
  assign o_count = cnt_reg;
  always_comb begin
    cnt_next = cnt_reg;
    if (i_restart) begin
      cnt_next = i_reload;
    end else if (i_en) begin
      cnt_next = (cnt_reg == W'(1)) ? i_reload : cnt_reg - W'(1);
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= RST_VAL;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : ubg_down_cnt
`default_nettype wire

//--- ubg_irq.sv
// sticky event status, write-one-to-clear, enable mask, level interrupt
// assumes write strobes are single-cycle pulses from the register port
`timescale 1ns/1ps
`default_nettype none
module ubg_irq #(
  parameter int N = 2,
  parameter logic [N-1:0] IEN_RST = '1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [N-1:0] i_event,
  input wire logic [N-1:0] i_gate,
  input wire logic i_clr_wr,
  input wire logic i_ien_wr,
  input wire logic [N-1:0] i_wdata,
  output logic [N-1:0] o_status,
  output logic [N-1:0] o_ien,
  output logic o_irq
);
  logic [N-1:0] stat_reg;
  logic [N-1:0] stat_next;
  logic [N-1:0] ien_reg;
  logic [N-1:0] ien_next;
  // ----------------------------------------------------------------
  // status and mask
  // ----------------------------------------------------------------
  always_comb begin
    // set beats clear so an event in the clearing cycle survives
    stat_next = (stat_reg & ~(i_clr_wr ? i_wdata : '0)) | i_event;
    ien_next = i_ien_wr ? i_wdata : ien_reg;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_reg <= '0;
      ien_reg <= IEN_RST;
    end else begin
      stat_reg <= stat_next;
      ien_reg <= ien_next;
    end
  end
  assign o_status = stat_reg;
  assign o_ien = ien_reg;
  assign o_irq = |(stat_reg & ien_reg & i_gate);
endmodule : ubg_irq
`default_nettype wire

//--- ubg_pkg.sv
// constants shared by the baud generator / timer block
// assumes a byte-wide register port with an 8-bit address
package ubg_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] UBG_CTRL_OFS = 8'hf3;
  localparam logic [7:0] UBG_DIV_OFS = 8'hf4;
  localparam logic [7:0] UBG_STAT_OFS = 8'hf5;
  localparam logic [7:0] UBG_CLR_OFS = 8'hf6;
  localparam logic [7:0] UBG_IEN_OFS = 8'hf7;
  // ----------------------------------------------------------------
  // serial_control_reg fields
  // ----------------------------------------------------------------
  localparam int UBG_TX_EN_BIT = 7;
  localparam int UBG_RX_EN_BIT = 6;
  localparam int UBG_IRQ_EN_BIT = 5;
  localparam int UBG_PAR_EN_BIT = 4;
  localparam int UBG_PAR_ODD_BIT = 3;
  localparam int UBG_BREAK_BIT = 2;
  localparam int UBG_STOP2_BIT = 1;
  localparam int UBG_MODE_BIT = 0;
  // ----------------------------------------------------------------
  // status / clear / enable fields
  // ----------------------------------------------------------------
  localparam int UBG_EV_N = 2;
  localparam int UBG_EV_RELOAD = 0;
  localparam int UBG_EV_MODE_ERR = 1;
  // ----------------------------------------------------------------
  // reset values and rates
  // ----------------------------------------------------------------
  localparam logic [7:0] UBG_CTRL_RST = 8'h00;
  localparam logic [7:0] UBG_DIV_RST = 8'hff;
  localparam logic [1:0] UBG_IEN_RST = 2'h3;
  // oversampling factor 16: a 4-bit down counter reloaded with 0 wraps every 16
  localparam int UBG_OVERSAMPLE = 16;
  localparam int UBG_PRE_W = $clog2(UBG_OVERSAMPLE);
  localparam logic [3:0] UBG_PRE_RELOAD = 4'h0;
endpackage : ubg_pkg

//--- ubg_uart_model.sv
// uart-side consumer of the rate strobes: measures strobe spacing and counts
// assumes strobes are one-cycle pulses on i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module ubg_uart_model (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_x16_tick,
  input wire logic i_bit_tick,
  output logic [15:0] o_x16_per,
  output logic [15:0] o_bit_per,
  output logic [15:0] o_x16_cnt,
  output logic [15:0] o_bit_cnt
);
  // ----------------------------------------------------------------
  // spacing meters
  // ----------------------------------------------------------------
  // the first period after a divisor change is mixed, so readers skip it
  logic [15:0] x16_age;
  logic [15:0] bit_age;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      x16_age <= 16'h0000;
      bit_age <= 16'h0000;
      o_x16_per <= 16'h0000;
      o_bit_per <= 16'h0000;
      o_x16_cnt <= 16'h0000;
      o_bit_cnt <= 16'h0000;
    end else begin
      x16_age <= i_x16_tick ? 16'h0001 : x16_age + 16'h0001;
      bit_age <= i_bit_tick ? 16'h0001 : bit_age + 16'h0001;
      if (i_x16_tick) begin
        o_x16_per <= x16_age;
        o_x16_cnt <= o_x16_cnt + 16'h0001;
      end
      if (i_bit_tick) begin
        o_bit_per <= bit_age;
        o_bit_cnt <= o_bit_cnt + 16'h0001;
      end
    end
  end
endmodule : ubg_uart_model
`default_nettype wire
